// *** verilog/esr_reporter.sv ***
// Error reporter: gates error events into system error hub messages.
// Assumes event inputs are one-cycle pulses on sys_clk_i; agp_mode_i is a
// level from a pin and is synchronised here.
`timescale 1ns/1ps
module esr_reporter #(
	parameter int unsigned QUEUE_DEPTH = esr_pkg::QUEUE_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Mode strap
	input wire logic agp_mode_i,
	// Register port
	input wire logic [esr_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [esr_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [esr_pkg::DATA_W-1:0] reg_rdata_o,
	// Primary error events
	input wire logic refresh_overrun_i,
	input wire logic hub_target_abort_i,
	input wire logic lock_nondram_i,
	input wire logic outside_aperture_i,
	input wire logic invalid_agp_access_i,
	input wire logic bad_translation_entry_i,
	// Bridge error events
	input wire logic bridge_parity_err_i,
	input wire logic bridge_target_abort_i,
	// Hub special cycle message
	output logic serr_msg_valid_o,
	input wire logic serr_msg_ready_i,
	output logic [esr_pkg::SRC_W-1:0] serr_msg_src_o,
	// Interrupt
	output logic irq_o
);
	if (QUEUE_DEPTH < 2 || (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("esr_reporter: QUEUE_DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic agp_s1;
		logic agp_s2;
		logic pcmd_serr;
		logic bcmd_serr;
		logic bridge_control_reg_perr;
		logic berr_tabort;
		logic [5:0] src_en;
		logic psts_sig;
		logic psts_rta;
		logic bsts_perr;
		logic bsts_sig;
		logic bsts_rta;
		logic [7:0] pend;
		logic [7:0] irq_sts;
		logic [7:0] irq_mask;
		logic [15:0] rd_data;
	} esr_state_t;

	esr_state_t r;
	esr_state_t n;
	logic [7:0] ev;
	logic [7:0] fire;
	logic [5:0] src_en_eff;
	logic agp;
	logic q_ready;
	logic push;
	logic [2:0] pick_idx;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [2:0] first_pending(input logic [7:0] p);
		first_pending = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (p[i])
				first_pending = i[2:0];
		end
	endfunction

	assign ev = {bridge_target_abort_i, bridge_parity_err_i,
		refresh_overrun_i, hub_target_abort_i, lock_nondram_i,
		outside_aperture_i, invalid_agp_access_i, bad_translation_entry_i};
	assign agp = r.agp_s2;
	// Enables only live in AGP mode
	assign src_en_eff = agp ? r.src_en : esr_pkg::SRC_EN_RST;
	// Primary sources need the global enable and their own bit;
	// bridge sources need their own command and enable bits
	assign fire = {ev[7] && r.bcmd_serr && r.berr_tabort,
		ev[6] && r.bcmd_serr && r.bridge_control_reg_perr,
		ev[5:0] & src_en_eff
		& {esr_pkg::NUM_PRI_SRC{r.pcmd_serr}}};
	// Per-source gating of bits 5 to 0 follows the same mask
	// One pending source moves into the queue per cycle
	assign pick_idx = first_pending(r.pend);
	assign push = (r.pend != 8'h00) && q_ready;
	assign reg_rdata_o = r.rd_data;
	assign irq_o = |(r.irq_sts & r.irq_mask);

	esr_msg_queue #(
		.WIDTH(esr_pkg::SRC_W),
		.DEPTH(QUEUE_DEPTH)
	) u_queue (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.in_valid_i(push),
		.in_ready_o(q_ready),
		.in_data_i(pick_idx),
		.out_valid_o(serr_msg_valid_o),
		.out_ready_i(serr_msg_ready_i),
		.out_data_o(serr_msg_src_o)
	);

	always_comb
	begin
		logic [15:0] rdv;
		logic [7:0] pend_clr;
		rdv = 16'h0000;
		pend_clr = 8'h00;
		n = r;
		n.agp_s1 = agp_mode_i;
		n.agp_s2 = r.agp_s1;

		// Queue hand-off; a new fire of the same source wins
		if (push)
			pend_clr[pick_idx] = 1'b1;
		n.pend = (r.pend & ~pend_clr) | fire;

		// Register writes
		if (reg_wr_i)
		begin
			if (hit(reg_addr_i, esr_pkg::OFF_PRI_CMD))
				n.pcmd_serr = reg_wdata_i[esr_pkg::CMD_SERR_BIT];
			if (hit(reg_addr_i, esr_pkg::OFF_BR_CMD))
				n.bcmd_serr = reg_wdata_i[esr_pkg::CMD_SERR_BIT];
			if (hit(reg_addr_i, esr_pkg::OFF_BR_CTRL))
				n.bridge_control_reg_perr = reg_wdata_i[esr_pkg::BRIDGE_CONTROL_REG_PERR_SERR_BIT];
			if (hit(reg_addr_i, esr_pkg::OFF_BR_ERR_EN))
				n.berr_tabort = reg_wdata_i[esr_pkg::BERR_TABORT_BIT];
			if (hit(reg_addr_i, esr_pkg::OFF_SRC_EN) && agp)
				n.src_en = reg_wdata_i[5:0];
			if (hit(reg_addr_i, esr_pkg::OFF_IRQ_MASK))
				n.irq_mask = reg_wdata_i[7:0];
			if (hit(reg_addr_i, esr_pkg::OFF_PRI_STS))
			begin
				n.psts_sig = r.psts_sig
					& ~reg_wdata_i[esr_pkg::STS_SIG_SERR_BIT];
				n.psts_rta = r.psts_rta
					& ~reg_wdata_i[esr_pkg::STS_RX_TABORT_BIT];
			end
			if (hit(reg_addr_i, esr_pkg::OFF_BR_STS))
			begin
				n.bsts_perr = r.bsts_perr & ~reg_wdata_i[esr_pkg::STS_PERR_BIT];
				n.bsts_sig = r.bsts_sig
					& ~reg_wdata_i[esr_pkg::STS_SIG_SERR_BIT];
				n.bsts_rta = r.bsts_rta
					& ~reg_wdata_i[esr_pkg::STS_RX_TABORT_BIT];
			end
			if (hit(reg_addr_i, esr_pkg::OFF_IRQ_STS))
				n.irq_sts = r.irq_sts & ~reg_wdata_i[7:0];
		end

		// Hardware sets win over software clears
		if (|fire[5:0])
			n.psts_sig = 1'b1;
		if (ev[esr_pkg::SRC_HUB_TABORT])
			n.psts_rta = 1'b1;
		if (ev[esr_pkg::SRC_BR_PERR])
			n.bsts_perr = 1'b1;
		if (|fire[7:6])
			n.bsts_sig = 1'b1;
		if (ev[esr_pkg::SRC_BR_TABORT])
			n.bsts_rta = 1'b1;
		n.irq_sts = n.irq_sts | ev;

		// Register reads, data valid in the next cycle only
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				esr_pkg::OFF_PRI_CMD:
					rdv[esr_pkg::CMD_SERR_BIT] = r.pcmd_serr;
				esr_pkg::OFF_PRI_STS:
				begin
					rdv[esr_pkg::STS_SIG_SERR_BIT] = r.psts_sig;
					rdv[esr_pkg::STS_RX_TABORT_BIT] = r.psts_rta;
				end
				esr_pkg::OFF_SRC_EN:
					if (agp)
						rdv[5:0] = r.src_en;
				esr_pkg::OFF_BR_CMD:
					rdv[esr_pkg::CMD_SERR_BIT] = r.bcmd_serr;
				esr_pkg::OFF_BR_STS:
				begin
					rdv[esr_pkg::STS_PERR_BIT] = r.bsts_perr;
					rdv[esr_pkg::STS_SIG_SERR_BIT] = r.bsts_sig;
					rdv[esr_pkg::STS_RX_TABORT_BIT] = r.bsts_rta;
				end
				esr_pkg::OFF_BR_CTRL:
					rdv[esr_pkg::BRIDGE_CONTROL_REG_PERR_SERR_BIT] = r.bridge_control_reg_perr;
				esr_pkg::OFF_BR_ERR_EN:
					rdv[esr_pkg::BERR_TABORT_BIT] = r.berr_tabort;
				esr_pkg::OFF_IRQ_STS:
					rdv[7:0] = r.irq_sts;
				esr_pkg::OFF_IRQ_MASK:
					rdv[7:0] = r.irq_mask;
				default:
					rdv = 16'h0000;
			endcase
		end
		n.rd_data = rdv;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			r <= '0;
		else
			r <= n;
	end

	// Checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_pri_gated(int i);
		ev[i] && agp && r.src_en[i] && r.pcmd_serr;
	endsequence

	sequence s_reported(int i);
		r.pend[i] ##[0:64] (push && pick_idx == i);
	endsequence

	property p_source_reports(int i);
		s_pri_gated(i) |=> s_reported(i);
	endproperty

	// Gated off means mode, own enable or global enable missing
	property p_source_silent(int i);
		(ev[i] && !(agp && r.src_en[i] && r.pcmd_serr) && !r.pend[i])
		|=> !r.pend[i];
	endproperty

	a_refresh_report: assert property (p_source_reports(5))
		else $error("refresh overrun not reported");
	a_refresh_silent: assert property (p_source_silent(5))
		else $error("disabled refresh overrun reported");
	a_hub_abort_report: assert property (p_source_reports(4))
		else $error("hub target abort not reported");
	a_lock_report: assert property (p_source_reports(3))
		else $error("lock to non-DRAM not reported");
	a_aperture_report: assert property (p_source_reports(2))
		else $error("outside aperture access not reported");
	a_invalid_agp_report: assert property (p_source_reports(1))
		else $error("invalid AGP access not reported");
	a_bad_entry_report: assert property (p_source_reports(0))
		else $error("invalid translation entry not reported");
	a_hub_abort_silent: assert property (p_source_silent(4))
		else $error("disabled hub target abort reported");
	a_lock_silent: assert property (p_source_silent(3))
		else $error("disabled lock to non-DRAM reported");
	a_aperture_silent: assert property (p_source_silent(2))
		else $error("disabled outside aperture access reported");
	a_invalid_agp_silent: assert property (p_source_silent(1))
		else $error("disabled invalid AGP access reported");
	a_bad_entry_silent: assert property (p_source_silent(0))
		else $error("disabled invalid translation entry reported");

	a_global_gate_off: assert property (
		(!r.pcmd_serr && r.pend[5:0] == 6'h00) |=> r.pend[5:0] == 6'h00)
		else $error("primary report without global enable");

	a_mode_hides_enables: assert property (
		(!agp && reg_rd_i && reg_addr_i == esr_pkg::OFF_SRC_EN)
		|=> reg_rdata_o == 16'h0000)
		else $error("source enables visible outside AGP mode");

	a_reserved_read_zero: assert property (
		(reg_rd_i && reg_addr_i == esr_pkg::OFF_SRC_EN)
		|=> reg_rdata_o[15:6] == 10'h000)
		else $error("reserved enable bits read nonzero");

	a_primary_status: assert property (
		(|fire[5:0]) |=> r.psts_sig)
		else $error("primary signalled flag not set");

	a_hub_abort_status: assert property (
		ev[4] |=> r.psts_rta)
		else $error("hub target abort flag not set");

	a_bridge_parity: assert property (
		ev[6] |=> r.bsts_perr && (r.bsts_sig || !$past(fire[6])))
		else $error("bridge parity flags wrong");

	a_bridge_abort: assert property (
		(ev[7] && r.bcmd_serr && r.berr_tabort) |=> r.bsts_rta && r.bsts_sig)
		else $error("bridge target abort flags wrong");

	a_single_message: assert property (
		(serr_msg_valid_o && !serr_msg_ready_i)
		|=> serr_msg_valid_o && $stable(serr_msg_src_o))
		else $error("message changed before acceptance");

	a_queue_order: assert property (
		(push && pick_idx == 3'h0 && r.pend[1]) |=> r.pend[1])
		else $error("lower pending source lost");

	// Pending sources wait while the queue is full
	a_queue_hold: assert property (
		(r.pend != 8'h00 && !q_ready)
		|=> (r.pend & $past(r.pend)) == $past(r.pend))
		else $error("pending source dropped while queue full");

	// A handed-off source leaves pending unless it fires again
	a_push_clears: assert property (
		(push && !fire[pick_idx]) |=> !r.pend[$past(pick_idx)])
		else $error("queued source still pending");

	// After every hand-off a message is offered to the hub in the next cycle
	sequence s_offered;
		push ##1 serr_msg_valid_o;
	endsequence

	a_msg_offered: assert property (
		push |-> s_offered)
		else $error("queued source not offered to hub");

	// Enables cannot change outside AGP mode
	a_enables_locked: assert property (
		(reg_wr_i && reg_addr_i == esr_pkg::OFF_SRC_EN && !agp)
		|=> $stable(r.src_en))
		else $error("source enables written outside AGP mode");

	a_parity_gate_off: assert property (
		(ev[6] && !(r.bcmd_serr && r.bridge_control_reg_perr) && !r.pend[6])
		|=> !r.pend[6])
		else $error("bridge parity reported while disabled");

	a_abort_gate_off: assert property (
		(ev[7] && !(r.bcmd_serr && r.berr_tabort) && !r.pend[7])
		|=> !r.pend[7])
		else $error("bridge target abort reported while disabled");

	a_bridge_rx_abort: assert property (
		ev[7] |=> r.bsts_rta)
		else $error("bridge received target abort flag not set");

	// Read data stands for one cycle only
	a_read_one_cycle: assert property (
		!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data outside its cycle");
endmodule

// *** verilog/esr_pkg.sv ***
// Constants shared by the error message reporter and its queue.
// Assumes one 25 MHz clock and a plain register port with 16-bit data.
// Overview of operation
// - The per-source enable register exists only in AGP mode.
// - Every report leaves as a hub message to the controller hub.
// - Primary sources report only with command bit 8 set.
// - Enable bit 5 reports memory refresh overrun.
// - Refresh overrun enable behaves like the graphics device control.
// - Enable bit 4 reports target abort on own hub cycles.
// - Enable bit 3 reports processor locks to non-DRAM memory.
// - Enable bit 2 reports AGP accesses outside the aperture.
// - Enable bit 1 reports outside hits in 640 KB-1 MB or above memory.
// - Enable bit 0 reports invalid translation entries.
// - Each error occurrence yields at most one message; repeats while still pending merge.
// - Any primary report sets primary status bit 14.
// - A received hub target abort also sets primary status bit 12.
// - Bridge parity needs command bit 8, control bit 2; sets 14, 15.
// - Bridge target abort needs bit 8, enable bit 0; sets 14, 12.
// - Bridge error enable register has its own offset, resets zero.
package esr_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned NUM_SRC = 8;
	localparam int unsigned SRC_W = 3;
	localparam int unsigned QUEUE_DEPTH = 4;

	// Register offsets
	localparam logic [7:0] OFF_PRI_CMD = 8'h04;
	localparam logic [7:0] OFF_PRI_STS = 8'h06;
	localparam logic [7:0] OFF_SRC_EN = 8'hCB;
	localparam logic [7:0] OFF_BR_CMD = 8'h44;
	localparam logic [7:0] OFF_BR_STS = 8'h46;
	localparam logic [7:0] OFF_BR_CTRL = 8'h7E;
	localparam logic [7:0] OFF_BR_ERR_EN = 8'h80;
	localparam logic [7:0] OFF_IRQ_STS = 8'hE0;
	localparam logic [7:0] OFF_IRQ_MASK = 8'hE2;

	// Field positions
	localparam int unsigned CMD_SERR_BIT = 8;
	localparam int unsigned STS_SIG_SERR_BIT = 14;
	localparam int unsigned STS_RX_TABORT_BIT = 12;
	localparam int unsigned STS_PERR_BIT = 15;
	localparam int unsigned BRIDGE_CONTROL_REG_PERR_SERR_BIT = 2;
	localparam int unsigned BERR_TABORT_BIT = 0;

	// Source codes; codes 0 to 5 equal their enable bit position
	localparam logic [2:0] SRC_BAD_TTE = 3'h0;
	localparam logic [2:0] SRC_INVALID_AGP = 3'h1;
	localparam logic [2:0] SRC_OUTSIDE_AP = 3'h2;
	localparam logic [2:0] SRC_LOCK_NONDRAM = 3'h3;
	localparam logic [2:0] SRC_HUB_TABORT = 3'h4;
	localparam logic [2:0] SRC_REFRESH = 3'h5;
	localparam logic [2:0] SRC_BR_PERR = 3'h6;
	localparam logic [2:0] SRC_BR_TABORT = 3'h7;
	localparam int unsigned NUM_PRI_SRC = 6;

	// Reset values
	localparam logic [5:0] SRC_EN_RST = 6'h00;
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;
endpackage

// *** verilog/esr_msg_queue.sv ***
// Message queue holding source codes awaiting a hub special cycle.
// Assumes both sides on sys_clk_i; depth a power of two.
`timescale 1ns/1ps
module esr_msg_queue #(
	parameter int unsigned WIDTH = 3,
	parameter int unsigned DEPTH = 4
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned PW = (DEPTH < 2) ? 1 : $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
	begin : g_bad_param
		$error("esr_msg_queue: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [PW:0] count;
	} esr_queue_t;

	esr_queue_t r;
	esr_queue_t n;
	logic push;
	logic pop;

	assign in_ready_o = (r.count != FULL_CNT);
	assign out_valid_o = (r.count != '0);
	assign out_data_o = r.mem[r.rptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb
	begin
		n = r;
		if (push)
		begin
			n.mem[r.wptr] = in_data_i;
			n.wptr = r.wptr + 1'b1;
		end
		if (pop)
			n.rptr = r.rptr + 1'b1;
		if (push && !pop)
			n.count = r.count + 1'b1;
		else if (pop && !push)
			n.count = r.count - 1'b1;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			r <= '0;
		else
			r <= n;
	end
endmodule

// *** testbench/esr_hub_model.sv ***
// Hub controller model taking system error special cycles.
// Assumes the reporter's clock and reset; the bench sets the pace.
`timescale 1ns/1ps
module esr_hub_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Pace control
	input wire logic stall_i,
	input wire logic slow_i,
	// Message port
	output logic msg_ready_o
);
	logic [1:0] cnt_r;

	// One special cycle taken per handshake
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_r <= 2'h0;
			msg_ready_o <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_r + 2'h1;
			msg_ready_o <= !stall_i && (!slow_i || cnt_r == 2'h3);
		end
	end
endmodule

// *** testbench/esr_reporter_tb_top.sv ***
// Bench for the error reporter: registers, events, hub messages, irq.
// Assumes the hub model paces message acceptance.
`timescale 1ns/1ps
`define CHK(a, b) check_val(32'(a), 32'(b))
module esr_reporter_tb_top;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic agp_mode_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic [7:0] ev = 8'h00;
	logic serr_msg_valid_o;
	logic serr_msg_ready_i;
	logic irq_o;
	logic [2:0] serr_msg_src_o;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic rd_d = 1'b0;
	logic [31:0] seed = 32'd8251;
	logic [31:0] r;
	int err_count = 0;
	int check_count = 0;
	logic [15:0] rd_q[$];
	logic [2:0] exp_q[$];

	initial
	begin
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	esr_reporter dut (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.agp_mode_i(agp_mode_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.refresh_overrun_i(ev[5]),
		.hub_target_abort_i(ev[4]),
		.lock_nondram_i(ev[3]),
		.outside_aperture_i(ev[2]),
		.invalid_agp_access_i(ev[1]),
		.bad_translation_entry_i(ev[0]),
		.bridge_parity_err_i(ev[6]),
		.bridge_target_abort_i(ev[7]),
		.serr_msg_valid_o(serr_msg_valid_o),
		.serr_msg_ready_i(serr_msg_ready_i),
		.serr_msg_src_o(serr_msg_src_o),
		.irq_o(irq_o)
	);

	esr_hub_model hub (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.stall_i(stall),
		.slow_i(slow),
		.msg_ready_o(serr_msg_ready_i)
	);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check_val(input logic [31:0] a, input logic [31:0] b);
		check_count++;
		if (a !== b)
		begin
			err_count++;
			$display("ERROR at %0t: got %0h expected %0h", $time, a, b);
		end
	endtask

	task automatic report_and_stop();
		$display("Checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		rd_q.push_back(e);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
	endtask

	task automatic fire(input logic [7:0] m);
		@(posedge sys_clk_i);
		ev <= m;
		@(posedge sys_clk_i);
		ev <= 8'h00;
	endtask

	// Waits for expected messages, then idles so strays show up
	task automatic drain();
		repeat (300)
		begin
			if (exp_q.size() != 0)
				@(posedge sys_clk_i);
		end
		repeat (12) @(posedge sys_clk_i);
		`CHK(exp_q.size(), 0);
	endtask

	task automatic irq_is(input logic v);
		repeat (2) @(posedge sys_clk_i);
		#1;
		`CHK(irq_o, v);
	endtask

	always @(posedge sys_clk_i)
	begin
		rd_d <= reg_rd_i;
		if (rd_d)
			`CHK(reg_rdata_o, rd_q.pop_front());
		if (serr_msg_valid_o === 1'b1 && serr_msg_ready_i === 1'b1)
		begin
			`CHK(exp_q.size() > 0, 1'b1);
			if (exp_q.size() > 0)
				`CHK(serr_msg_src_o, exp_q.pop_front());
		end
	end

	initial
	begin
		#(40 * 30000);
		err_count++;
		report_and_stop();
	end

	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		wr(8'hCB, 16'h003F);
		rd(8'hCB, 16'h0000);
		agp_mode_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		rd(8'hCB, 16'h0000);
		wr(8'hCB, 16'h00FF);
		rd(8'hCB, 16'h003F);
		rd(8'h80, 16'h0000);
		rd(8'h10, 16'h0000);
		fire(8'h08);
		drain();
		wr(8'h04, 16'h0100);
		rd(8'h04, 16'h0100);
		wr(8'hCB, 16'h001F);
		fire(8'h20);
		drain();
		wr(8'hCB, 16'h0000);
		fire(8'h1F);
		drain();
		wr(8'hCB, 16'h003F);
		for (int i = 0; i < 6; i++)
		begin
			exp_q.push_back(3'(i));
			fire(8'(1 << i));
			drain();
		end
		rd(8'h06, 16'h5000);
		wr(8'h06, 16'h5000);
		rd(8'h06, 16'h0000);
		// Simultaneous events while the hub stalls
		stall <= 1'b1;
		for (int i = 0; i < 6; i++)
			exp_q.push_back(3'(i));
		fire(8'h3F);
		repeat (10) @(posedge sys_clk_i);
		stall <= 1'b0;
		drain();
		fire(8'hC0);
		drain();
		wr(8'h44, 16'h0100);
		wr(8'h7E, 16'h0004);
		rd(8'h44, 16'h0100);
		rd(8'h7E, 16'h0004);
		exp_q.push_back(3'h6);
		fire(8'hC0);
		drain();
		wr(8'h80, 16'h0001);
		rd(8'h80, 16'h0001);
		exp_q.push_back(3'h7);
		fire(8'h80);
		drain();
		rd(8'h46, 16'hD000);
		for (int i = 0; i < 12; i++)
		begin
			r = xs();
			slow <= r[8];
			exp_q.push_back(3'(r % 6));
			fire(8'(1 << (r % 6)));
			drain();
		end
		wr(8'hE0, 16'h00FF);
		rd(8'hE0, 16'h0000);
		exp_q.push_back(3'h0);
		fire(8'h01);
		drain();
		rd(8'hE0, 16'h0001);
		irq_is(1'b0);
		wr(8'hE2, 16'h0001);
		rd(8'hE2, 16'h0001);
		irq_is(1'b1);
		wr(8'hE0, 16'h0001);
		irq_is(1'b0);
		report_and_stop();
	end
endmodule
